// [logic/pocr_pkg.sv]
package pocr_pkg;
	// model-specific register address of the power-on configuration word
	localparam logic [31:0] POCR_MSR_ADDR = 32'h0000_002A;
	localparam int POCR_WIDTH = 64;
	// read/write control bit positions
	localparam int POCR_BIT_DATA_CHK = 1;
	localparam int POCR_BIT_RESP_CHK = 2;
	localparam int POCR_BIT_ADDR_ERR_DRV = 3;
	localparam int POCR_BIT_BUS_ERR_REQ = 4;
	localparam int POCR_BIT_BUS_ERR_INT = 6;
	localparam int POCR_BIT_BUS_INIT_DRV = 7;
	localparam int POCR_BIT_LOW_POWER = 26;
	// read-only strap field positions
	localparam int POCR_BIT_OUT_TRI = 8;
	localparam int POCR_BIT_BIST = 9;
	localparam int POCR_BIT_ADDR_ERR_OBS = 10;
	localparam int POCR_BIT_BUS_INIT_OBS = 12;
	localparam int POCR_BIT_IOQ_ONE = 13;
	localparam int POCR_BIT_VEC_1M = 14;
	localparam int POCR_BIT_LOCKSTEP = 15;
	localparam int POCR_LSB_CLUSTER = 16;
	localparam int POCR_LSB_ARB_ID = 20;
	localparam int POCR_LSB_CLK_RATIO = 22;
	localparam int POCR_STRAP_W = 14;
	// values after reset of the writable enables
	localparam logic POCR_RST_DATA_CHK = 1'b0;
	localparam logic POCR_RST_RESP_CHK = 1'b0;
	localparam logic POCR_RST_ADDR_ERR_DRV = 1'b0;
	localparam logic POCR_RST_BUS_ERR_REQ = 1'b0;
	localparam logic POCR_RST_BUS_ERR_INT = 1'b0;
	localparam logic POCR_RST_BUS_INIT_DRV = 1'b0;
	localparam logic POCR_RST_LOW_POWER = 1'b0;
	// cycles a strap must settle through its synchroniser before reset release
	localparam int POCR_SYNC_CYCLES = 2;
	// wake-up sequencing of the core clock
	typedef enum logic {POCR_RUN, POCR_WAIT_WAKE} pocr_wake_t;
endpackage : pocr_pkg

// [logic/pocr_strap_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface pocr_strap_if;
	logic [pocr_pkg::POCR_STRAP_W-1:0] straps;
	// sampler fills the captured straps, register bank only reads them
	modport sampler (output straps);
	modport bank (input straps);
endinterface : pocr_strap_if
`default_nettype wire

// [logic/pocr_strap_sampler.sv]
`timescale 1ns/1ps
`default_nettype none
module pocr_strap_sampler (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [pocr_pkg::POCR_STRAP_W-1:0] strap_pins_i,
	pocr_strap_if.sampler cap
);
	import pocr_pkg::*;
	logic [POCR_STRAP_W-1:0] meta_r;
	logic [POCR_STRAP_W-1:0] sync_r;
	logic [POCR_STRAP_W-1:0] held_r;
	// two-flop synchroniser; the first stage feeds only the second
	always_ff @(posedge clk_i) begin
		meta_r <= strap_pins_i;
		sync_r <= meta_r;
	end
	// straps track the pins while reset is low and freeze at release
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			held_r <= sync_r; // R10
		end
	end
	assign cap.straps = held_r;
	// once out of reset the captured straps never move
	a_strap_frozen: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R10
		$past(rst_n_i) |-> $stable(held_r)) else $error("strap changed after reset");
endmodule : pocr_strap_sampler
`default_nettype wire

// [logic/pocr_power_on_config.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: 64-bit configuration word at address 2AH
// R2: bit 1 enables data error checking
// R3: bit 2 enables response check, mismatch observation
// R4: bit 4 drives bus error for requests
// R5: bit 6 drives bus error for internal errors
// R6: bit 13 reports queue depth, 1=one, 0=eight
// R7: bit 14 reports reset vector location
// R8: bit 0 reserved, reads zero, ignores writes
// R9: low power stops core clock awaiting wake-up
// R10: strap fields sampled at reset, ignore writes
module pocr_power_on_config (
	// clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RESET_N_I,
	// model-specific register access
	input wire logic [31:0] MSR_ADDR_I,
	input wire logic MSR_RD_I,
	input wire logic MSR_WR_I,
	input wire logic [pocr_pkg::POCR_WIDTH-1:0] MSR_WDATA_I,
	output logic [pocr_pkg::POCR_WIDTH-1:0] MSR_RDATA_O,
	output logic MSR_ACK_O,
	output logic MSR_MISS_O,
	// power-on strap pins
	input wire logic [pocr_pkg::POCR_STRAP_W-1:0] STRAP_PINS_I,
	// error sources and checking enables
	input wire logic REQ_ERR_I,
	input wire logic INT_ERR_I,
	input wire logic REDUNDANCY_MISMATCH_I,
	output logic DATA_ERR_CHK_EN_O,
	output logic RESP_ERR_CHK_EN_O,
	output logic REDUNDANCY_MISMATCH_ERROR_O,
	output logic ADDRESS_ERROR_DRV_EN_O,
	output logic BUS_INIT_DRV_EN_O,
	// open-drain bus error pin, enable low while pulling low
	output logic BUS_ERROR_PIN_O,
	output logic BUS_ERROR_PIN_OE_N_O,
	// core clock control
	input wire logic INIT_EVENT_I,
	input wire logic WAKEUP_MESSAGE_I,
	output logic CORE_CLK_STOP_O
);
	import pocr_pkg::*;

	pocr_strap_if strap_bus ();
	logic data_chk_r;
	logic resp_chk_r;
	logic addr_err_drv_r;
	logic bus_err_req_r;
	logic bus_err_int_r;
	logic bus_init_drv_r;
	logic low_power_r;
	logic [POCR_WIDTH-1:0] rdata_r;
	logic ack_r;
	logic miss_r;
	logic bus_err_drive_r;
	logic bus_err_drive_nxt;
	pocr_wake_t wake_r;
	pocr_wake_t wake_nxt;
	logic [POCR_WIDTH-1:0] word;
	logic hit;
	logic wr_hit;
	logic [POCR_STRAP_W-1:0] st;

	pocr_strap_sampler u_sampler (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RESET_N_I),
		.strap_pins_i(STRAP_PINS_I),
		.cap(strap_bus.sampler)
	);
	assign st = strap_bus.straps;

	// address decode, only one word lives here
	assign hit = (MSR_ADDR_I == POCR_MSR_ADDR); // R1
	assign wr_hit = MSR_WR_I && hit;

	// read view: strap order is out_tri,bist,addr_err_obs,bus_init_obs,ioq,vec,lockstep,
	// cluster[1:0],arb[1:0],ratio[2:0] from straps bit 0 upward
	always_comb begin
		word = '0; // R8
		word[POCR_BIT_DATA_CHK] = data_chk_r;
		word[POCR_BIT_RESP_CHK] = resp_chk_r;
		word[POCR_BIT_ADDR_ERR_DRV] = addr_err_drv_r;
		word[POCR_BIT_BUS_ERR_REQ] = bus_err_req_r;
		word[POCR_BIT_BUS_ERR_INT] = bus_err_int_r;
		word[POCR_BIT_BUS_INIT_DRV] = bus_init_drv_r;
		word[POCR_BIT_OUT_TRI] = st[0]; // R10
		word[POCR_BIT_BIST] = st[1];
		word[POCR_BIT_ADDR_ERR_OBS] = st[2];
		word[POCR_BIT_BUS_INIT_OBS] = st[3];
		word[POCR_BIT_IOQ_ONE] = st[4]; // R6
		word[POCR_BIT_VEC_1M] = st[5]; // R7
		word[POCR_BIT_LOCKSTEP] = st[6];
		word[POCR_LSB_CLUSTER +: 2] = st[8:7];
		word[POCR_LSB_ARB_ID +: 2] = st[10:9];
		word[POCR_LSB_CLK_RATIO +: 3] = st[13:11];
		word[POCR_BIT_LOW_POWER] = low_power_r;
	end

	// writable enables; strap and reserved bits are not stored from writes
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			data_chk_r <= POCR_RST_DATA_CHK;
			resp_chk_r <= POCR_RST_RESP_CHK;
			addr_err_drv_r <= POCR_RST_ADDR_ERR_DRV;
			bus_err_req_r <= POCR_RST_BUS_ERR_REQ;
			bus_err_int_r <= POCR_RST_BUS_ERR_INT;
			bus_init_drv_r <= POCR_RST_BUS_INIT_DRV;
			low_power_r <= POCR_RST_LOW_POWER;
		end else if (wr_hit) begin
			data_chk_r <= MSR_WDATA_I[POCR_BIT_DATA_CHK]; // R2
			resp_chk_r <= MSR_WDATA_I[POCR_BIT_RESP_CHK]; // R3
			addr_err_drv_r <= MSR_WDATA_I[POCR_BIT_ADDR_ERR_DRV];
			bus_err_req_r <= MSR_WDATA_I[POCR_BIT_BUS_ERR_REQ]; // R4
			bus_err_int_r <= MSR_WDATA_I[POCR_BIT_BUS_ERR_INT]; // R5
			bus_init_drv_r <= MSR_WDATA_I[POCR_BIT_BUS_INIT_DRV];
			low_power_r <= MSR_WDATA_I[POCR_BIT_LOW_POWER]; // R9
		end
	end

	// one-cycle answer to every access; miss flags an unknown address
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			rdata_r <= '0;
			ack_r <= 1'b0;
			miss_r <= 1'b0;
		end else begin
			ack_r <= MSR_RD_I || MSR_WR_I;
			miss_r <= (MSR_RD_I || MSR_WR_I) && !hit;
			if (MSR_RD_I) begin
				rdata_r <= hit ? word : '0; // R1
			end
		end
	end

	// bus error drive, registered so the pin never glitches on decode
	assign bus_err_drive_nxt = (REQ_ERR_I && bus_err_req_r) || (INT_ERR_I && bus_err_int_r); // R4 R5
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			bus_err_drive_r <= 1'b0;
		end else begin
			bus_err_drive_r <= bus_err_drive_nxt;
		end
	end

	// wait for the wake-up message after an init; a message in the same
	// cycle as a new init wins, so the core is never left stopped
	always_comb begin
		wake_nxt = wake_r;
		unique case (wake_r)
			POCR_RUN: begin
				if (INIT_EVENT_I && !WAKEUP_MESSAGE_I) begin
					wake_nxt = POCR_WAIT_WAKE;
				end
			end
			POCR_WAIT_WAKE: begin
				if (WAKEUP_MESSAGE_I) begin
					wake_nxt = POCR_RUN; // R9
				end
			end
		endcase
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			wake_r <= POCR_RUN;
		end else begin
			wake_r <= wake_nxt;
		end
	end

	// outputs
	assign MSR_RDATA_O = rdata_r;
	assign MSR_ACK_O = ack_r;
	assign MSR_MISS_O = miss_r;
	assign DATA_ERR_CHK_EN_O = data_chk_r; // R2
	assign RESP_ERR_CHK_EN_O = resp_chk_r; // R3
	assign REDUNDANCY_MISMATCH_ERROR_O = REDUNDANCY_MISMATCH_I && resp_chk_r; // R3
	assign ADDRESS_ERROR_DRV_EN_O = addr_err_drv_r;
	assign BUS_INIT_DRV_EN_O = bus_init_drv_r;
	assign BUS_ERROR_PIN_O = 1'b0;
	assign BUS_ERROR_PIN_OE_N_O = !bus_err_drive_r;
	assign CORE_CLK_STOP_O = (wake_r == POCR_WAIT_WAKE) && low_power_r; // R9

	// assertions
	sequence s_rd_hit;
		MSR_RD_I && hit;
	endsequence
	sequence s_init_wait;
		INIT_EVENT_I && !WAKEUP_MESSAGE_I ##1 !WAKEUP_MESSAGE_I;
	endsequence

	a_read_word_map: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // R1
		s_rd_hit |=> MSR_RDATA_O == $past(word) && MSR_ACK_O) else $error("read data wrong");
	a_reserved_zero: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // R8
		MSR_ACK_O |-> !MSR_RDATA_O[0] && MSR_RDATA_O[63:27] == '0) else $error("reserved bit set");
	// holes between the strap fields must read zero as well
	a_reserved_holes: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // R10
		MSR_ACK_O |-> !MSR_RDATA_O[5] && !MSR_RDATA_O[11] && MSR_RDATA_O[19:18] == 2'h0
		&& !MSR_RDATA_O[25]) else $error("reserved hole set");
	a_data_chk_write: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // R2
		wr_hit |=> DATA_ERR_CHK_EN_O == $past(MSR_WDATA_I[1])) else $error("data check enable");
	a_mismatch_gate: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // R3
		REDUNDANCY_MISMATCH_ERROR_O |-> RESP_ERR_CHK_EN_O && REDUNDANCY_MISMATCH_I)
		else $error("mismatch leak");
	a_req_err_drive: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // R4
		REQ_ERR_I && bus_err_req_r |=> !BUS_ERROR_PIN_OE_N_O) else $error("request error not driven");
	a_int_err_quiet: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // R5
		!BUS_ERROR_PIN_OE_N_O |-> $past(INT_ERR_I && bus_err_int_r)
		|| $past(REQ_ERR_I && bus_err_req_r)) else $error("bus error driven without cause");
	a_queue_depth_bit: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // R6
		s_rd_hit |=> MSR_RDATA_O[13] == st[4] && MSR_RDATA_O[14] == st[5])
		else $error("strap view wrong");
	a_strap_no_write: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // R10
		wr_hit |=> $stable(word[24:8])) else $error("strap field took a write");
	a_clock_stop: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // R9
		s_init_wait |-> CORE_CLK_STOP_O == low_power_r) else $error("clock stop wrong");
	a_wake_restart: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // R9
		WAKEUP_MESSAGE_I |=> !CORE_CLK_STOP_O) else $error("core not restarted");
endmodule : pocr_power_on_config
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pocr_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] addr = 32'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [63:0] wd = 64'h0;
	logic [63:0] rdat;
	logic ack, miss, dce, rce, rme, aed, bid, bep, oen, cstop;
	logic [13:0] strap = 14'h2A55;
	logic req_e = 1'b0;
	logic int_e = 1'b0;
	logic mism = 1'b0;
	logic init_e = 1'b0;
	logic wake = 1'b0;
	int fail_count = 0;
	int tests_run = 0;
	// 10 MHz clock
	always #50 sys_clk = ~sys_clk;
	pocr_power_on_config dut_u (.SYS_CLK_I(sys_clk), .RESET_N_I(rst_n), .MSR_ADDR_I(addr),
		.MSR_RD_I(rd), .MSR_WR_I(wr), .MSR_WDATA_I(wd), .MSR_RDATA_O(rdat), .MSR_ACK_O(ack),
		.MSR_MISS_O(miss), .STRAP_PINS_I(strap), .REQ_ERR_I(req_e), .INT_ERR_I(int_e),
		.REDUNDANCY_MISMATCH_I(mism), .DATA_ERR_CHK_EN_O(dce), .RESP_ERR_CHK_EN_O(rce),
		.REDUNDANCY_MISMATCH_ERROR_O(rme), .ADDRESS_ERROR_DRV_EN_O(aed),
		.BUS_INIT_DRV_EN_O(bid), .BUS_ERROR_PIN_O(bep), .BUS_ERROR_PIN_OE_N_O(oen),
		.INIT_EVENT_I(init_e), .WAKEUP_MESSAGE_I(wake), .CORE_CLK_STOP_O(cstop));
	task automatic cmp_word(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_word
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_word({63'h0, got}, {63'h0, exp});
	endtask : cmp_bit
	// strap vector placed at its read-only field positions, rest zero
	function automatic logic [63:0] strap_word(input logic [13:0] s);
		logic [63:0] w;
		w = 64'h0;
		w[12:8] = {s[3], 1'b0, s[2:0]};
		w[15:13] = s[6:4];
		w[17:16] = s[8:7];
		w[21:20] = s[10:9];
		w[24:22] = s[13:11];
		return w;
	endfunction : strap_word
	// one access, request held for a single edge, answer sampled next cycle
	task automatic acc(input logic w, input logic [31:0] a, input logic [63:0] d);
		@(negedge sys_clk);
		addr = a;
		wr = w;
		rd = !w;
		wd = d;
		@(negedge sys_clk);
		wr = 1'b0;
		rd = 1'b0;
		cmp_bit(ack, 1'b1);
		cmp_bit(miss, a !== POCR_MSR_ADDR);
	endtask : acc
	task automatic t_reset;
		acc(1'b0, 32'h2A, 64'h0);
		cmp_word(rdat, strap_word(strap));
		$display("test reset_values done");
	endtask : t_reset
	task automatic t_write;
		acc(1'b1, 32'h2A, 64'hFFFF_FFFF_FFFF_FFFF);
		cmp_bit(dce & rce & aed & bid, 1'b1);
		strap = ~strap;
		acc(1'b0, 32'h2A, 64'h0);
		cmp_word(rdat, strap_word(~strap) | 64'h0400_00DE);
		acc(1'b1, 32'h2A, 64'h0);
		cmp_bit(dce | rce | aed | bid, 1'b0);
		$display("test write_fields done");
	endtask : t_write
	task automatic t_buserr;
		// both causes with both drive enables clear: pin must stay released
		req_e = 1'b1;
		int_e = 1'b1;
		@(negedge sys_clk);
		cmp_bit(oen, 1'b1);
		req_e = 1'b0;
		int_e = 1'b0;
		acc(1'b1, 32'h2A, 64'h10);
		req_e = 1'b1;
		@(negedge sys_clk);
		cmp_bit(oen, 1'b0);
		cmp_bit(bep, 1'b0);
		req_e = 1'b0;
		int_e = 1'b1;
		@(negedge sys_clk);
		cmp_bit(oen, 1'b1);
		acc(1'b1, 32'h2A, 64'h44);
		@(negedge sys_clk);
		cmp_bit(oen, 1'b0);
		int_e = 1'b0;
		mism = 1'b1;
		#1 cmp_bit(rme, 1'b1);
		acc(1'b1, 32'h2A, 64'h0);
		cmp_bit(rme, 1'b0);
		mism = 1'b0;
		$display("test bus_error done");
	endtask : t_buserr
	task automatic t_unmapped;
		acc(1'b1, 32'h2B, 64'hFFFF_FFFF_FFFF_FFFF);
		acc(1'b0, 32'h2B, 64'h0);
		cmp_word(rdat, 64'h0);
		acc(1'b0, 32'h2A, 64'h0);
		cmp_word(rdat, strap_word(~strap));
		$display("test unmapped done");
	endtask : t_unmapped
	// stop only with low power set, and released by the wake-up message
	task automatic t_clkstop(input logic lp);
		acc(1'b1, 32'h2A, {37'h0, lp, 26'h0});
		init_e = 1'b1;
		@(negedge sys_clk);
		init_e = 1'b0;
		cmp_bit(cstop, lp);
		@(negedge sys_clk);
		wake = 1'b1;
		@(negedge sys_clk);
		wake = 1'b0;
		cmp_bit(cstop, 1'b0);
		// init and wake-up in one cycle: core must keep running
		@(negedge sys_clk);
		init_e = 1'b1;
		wake = 1'b1;
		@(negedge sys_clk);
		init_e = 1'b0;
		wake = 1'b0;
		cmp_bit(cstop, 1'b0);
		$display("test clock_stop done");
	endtask : t_clkstop
	// reset again in mid-run: enables clear and straps are captured anew
	task automatic t_rereset;
		acc(1'b1, 32'h2A, 64'hFFFF_FFFF_FFFF_FFFF);
		@(negedge sys_clk);
		rst_n = 1'b0;
		strap = 14'h0F0F;
		// straps need the synchroniser depth plus capture edges while held
		repeat (POCR_SYNC_CYCLES + 2) @(negedge sys_clk);
		cmp_bit(oen, 1'b1);
		rst_n = 1'b1;
		acc(1'b0, 32'h2A, 64'h0);
		cmp_word(rdat, strap_word(14'h0F0F));
		$display("test mid_run_reset done");
	endtask : t_rereset
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	// main sequence
	initial begin
		repeat (12) @(negedge sys_clk);
		rst_n = 1'b1;
		t_reset();
		t_write();
		t_buserr();
		t_unmapped();
		t_clkstop(1'b1);
		t_clkstop(1'b0);
		t_rereset();
		tally_and_finish();
	end
	// watchdog, well past the ~60 cycles the tests need
	initial begin
		#(100 * 2000);
		fail_count++;
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
